// ### dv/fisr_host.sv
module fisr_host (
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic tmo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    tmo = 1'b0;
  end

  // Bounded wait for the slave to accept the current phase
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1 && n < 64) begin
      @(posedge core_clk);
      n++;
    end
    if (hready !== 1'b1) tmo <= 1'b1;
  endtask : wait_rdy

  // One single word transfer; read data taken at the data phase edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
endmodule : fisr_host

// ### dv/fisr_top_tb.sv
`include "fisr_params.svh"

module fisr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] st1 = `FISR_IDX_HDLC1_TX;
  localparam logic [7:0] st2 = `FISR_IDX_ALARMS;
  localparam logic [7:0] st3 = `FISR_IDX_TIMERS_SLIPS;
  localparam logic [7:0] st4 = `FISR_IDX_HDLC2_TX_SLIP;
  localparam logic [7:0] cfg = `FISR_IDX_CFG;
  localparam logic [7:0] emask = `FISR_IDX_ERRMASK;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, tmo;
  logic tx1_hold, tx2_hold, tx1_abort, tx2_abort, irq_pin;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, dd;
  logic [3:0] global_irq_summary;
  logic [35:0] s = '0;
  fisr_pkg::fisr_err_src_t err_src = '0;
  wire tx_frame_start = s[0], tx_multiframe_start = s[1], rx1_byte_in = s[2], rx1_fifo_full = s[3];
  wire tx1_last_bit_sent = s[4], tx1_fifo_empty = s[5], tx1_fifo_dry = s[6], tx1_message_end_cmd = s[7];
  wire su_err_exceed = s[8], su_err_invalid_cause = s[9], rx1_frame_end = s[10], rx1_frame_valid = s[11];
  wire tx_line_open = s[12], tx_line_short = s[13], tx1_pool_space = s[14], align_loss_status = s[15];
  wire mf_align_loss_status = s[16], blue_alarm_status = s[17], red_alarm_status = s[18];
  wire remote_alarm_status = s[19];
  wire rx_line_tick = s[20], llb_code_raw = s[21], prbs_sync = s[22], rx_slip_neg_evt = s[23];
  wire rx_slip_pos_evt = s[24], tx_slip_pos_evt = s[25], tx_slip_neg_evt = s[26], rx2_msg_end = s[27];
  wire rx2_frame_start = s[28], rx2_byte_in = s[29], rx2_fifo_full = s[30], rx2_frame_end = s[31];
  wire tx2_last_bit_sent = s[32], tx2_fifo_empty = s[33], tx2_fifo_dry = s[34], tx2_message_end_cmd = s[35];
  int err_total = 0;
  int comparisons = 0;
  int n_ab = 0;

  assign hready = hreadyout;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (tx1_abort === 1'b1) n_ab <= n_ab + 1;

  // Short second and loop-code qualification keep the run brief
  fisr_top #(.SEC_TICKS(10), .LLB_CYCLES(20)) dut_u (.*);
  fisr_host host_u (.*);

  task automatic wrap_up();
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : ck

  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask : w

  task automatic lv(input int i, input logic v);
    s[i] <= v;
    w(3);
  endtask : lv

  task automatic pu(input int i, input int n = 1);
    repeat (n) begin
      s[i] <= 1'b1;
      w(1);
      s[i] <= 1'b0;
      w(1);
    end
    w(2);
  endtask : pu

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    host_u.xfer(1'b0, idx, 32'h0000_0000, d);
    ck($sformatf("reg %h", idx), {24'h00_0000, e}, d);
  endtask : rc

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    host_u.xfer(1'b1, idx, {24'h00_0000, v}, dd);
  endtask : wr

  // Summary outputs are combinational; let the edge settle first
  task automatic pin(input logic e, input logic [3:0] g);
    #1;
    ck("irq_pin", {31'h0, e}, {31'h0, irq_pin});
    ck("summary", {28'h0, g}, {28'h0, global_irq_summary});
  endtask : pin

  task automatic hold(input logic e, input logic g);
    #1;
    ck("hold", {31'h0, e}, {31'h0, g});
  endtask : hold

  task automatic s_reset();
    rc(cfg, 8'h08);
    rc(`FISR_IDX_MASK1, 8'hff);
    rc(emask, 8'h00);
    for (int i = 0; i < 4; i++) rc(st1 + 8'(i), 8'h00);
    rc(`FISR_IDX_SUMMARY, 8'h00);
    ck("hresp", 32'h0, {31'h0, hresp});
    ck("hreadyout", 32'h1, {31'h0, hreadyout});
    wr(8'h10, 8'hff);
    rc(8'h10, 8'h00);
    for (int i = 1; i < 5; i++) wr(cfg + 8'(i), 8'h00);
    pin(1'b0, 4'h0);
  endtask : s_reset

  task automatic s_align();
    lv(15, 1'b1);
    pin(1'b1, 4'h2);
    lv(15, 1'b0);
    rc(st2, 8'hc0);
    pin(1'b0, 4'h0);
    rc(st2, 8'h00);
  endtask : s_align

  task automatic s_mask();
    wr(`FISR_IDX_MASK2, 8'hff);
    wr(cfg, 8'h0b);
    lv(17, 1'b1);
    pin(1'b0, 4'h0);
    rc(st2, 8'h08);
    lv(17, 1'b0);
    rc(st2, 8'h08);
    wr(cfg, 8'h08);
    lv(18, 1'b1);
    rc(st2, 8'h00);
    lv(18, 1'b0);
    wr(`FISR_IDX_MASK2, 8'h00);
    lv(17, 1'b1);
    rc(st2, 8'h08);
    lv(17, 1'b0);
    rc(st2, 8'h00);
  endtask : s_mask

  task automatic s_alarm();
    wr(cfg, 8'h28);
    lv(16, 1'b1);
    rc(st2, 8'h10);
    lv(16, 1'b0);
    rc(st2, 8'h20);
    wr(cfg, 8'h08);
    lv(16, 1'b1);
    lv(16, 1'b0);
    rc(st2, 8'h00);
    lv(19, 1'b1);
    rc(st2, 8'h01);
    lv(19, 1'b0);
    rc(st2, 8'h02);
    wr(cfg, 8'h88);
    w(2);
    rc(st2, 8'h7d);
    rc(st3, 8'h03);
    wr(cfg, 8'h08);
    w(3);
    rc(st2, 8'hff);
    rc(st2, 8'h00);
    rc(st3, 8'h03);
  endtask : s_alarm

  task automatic s_tx1();
    lv(3, 1'b1);
    pu(2);
    lv(3, 1'b0);
    pu(2);
    rc(st1, 8'h40);
    lv(5, 1'b1);
    pu(4);
    rc(st1, 8'h20);
    wr(cfg, 8'h00);
    pu(4);
    rc(st1, 8'h00);
    wr(cfg, 8'h08);
    lv(5, 1'b0);
    lv(7, 1'b1);
    pu(6);
    rc(st1, 8'h00);
    lv(7, 1'b0);
    pu(6);
    hold(1'b1, tx1_hold);
    ck("aborts", 32'h1, n_ab);
    rc(st1, 8'h10);
    hold(1'b0, tx1_hold);
    lv(12, 1'b1);
    rc(st1, 8'h02);
    lv(12, 1'b0);
    rc(st1, 8'h00);
    lv(13, 1'b1);
    rc(st1, 8'h02);
    lv(13, 1'b0);
    rc(st1, 8'h02);
    lv(14, 1'b1);
    rc(st1, 8'h01);
    lv(14, 1'b0);
    rc(st1, 8'h00);
  endtask : s_tx1

  task automatic s_ss7();
    wr(cfg, 8'h18);
    lv(9, 1'b1);
    pu(8);
    lv(9, 1'b0);
    rc(st1, 8'h04);
    pu(10);
    rc(st1, 8'h04);
    lv(11, 1'b1);
    pu(10);
    lv(11, 1'b0);
    pu(10);
    rc(st1, 8'h00);
    wr(cfg, 8'h08);
    pu(8);
    rc(st1, 8'h00);
  endtask : s_ss7

  task automatic s_frame();
    pu(1);
    rc(st1, 8'h88);
    wr(cfg, 8'h48);
    pu(1);
    rc(st1, 8'h08);
    wr(cfg, 8'h28);
    pu(0, 23);
    rc(st1, 8'h00);
    pu(0);
    rc(st1, 8'h80);
    wr(cfg, 8'h08);
  endtask : s_frame

  task automatic one_second(input logic [6:0] e, input int n);
    err_src <= e;
    w(1);
    err_src <= 7'h00;
    pu(20, n);
  endtask : one_second

  task automatic s_timers();
    one_second(7'h01, 9);
    rc(st3, 8'h00);
    pu(20);
    rc(st3, 8'h40);
    wr(emask, 8'h01);
    one_second(7'h01, 10);
    rc(st3, 8'hc0);
    one_second(7'h40, 10);
    rc(st3, 8'h40);
    lv(21, 1'b1);
    w(25);
    rc(st3, 8'h04);
    lv(21, 1'b0);
    rc(st3, 8'h04);
    lv(21, 1'b1);
    w(12);
    lv(21, 1'b0);
    rc(st3, 8'h00);
    wr(cfg, 8'h0c);
    lv(22, 1'b1);
    rc(st3, 8'h04);
    lv(22, 1'b0);
    rc(st3, 8'h04);
    wr(cfg, 8'h08);
    lv(22, 1'b1);
    lv(22, 1'b0);
    rc(st3, 8'h00);
    pu(23);
    pin(1'b1, 4'h4);
    rc(st3, 8'h02);
    pu(24);
    rc(st3, 8'h01);
  endtask : s_timers

  task automatic s_ch2();
    pu(25);
    rc(st4, 8'h80);
    pu(26);
    pu(27);
    rc(st4, 8'h60);
    pu(28);
    pu(29, 31);
    rc(st4, 8'h10);
    pu(29);
    rc(st4, 8'h01);
    lv(30, 1'b1);
    pu(29);
    lv(30, 1'b0);
    lv(33, 1'b1);
    pu(32);
    lv(33, 1'b0);
    pin(1'b1, 4'h8);
    rc(st4, 8'h0c);
    pu(34);
    hold(1'b1, tx2_hold);
    rc(st4, 8'h02);
    hold(1'b0, tx2_hold);
  endtask : s_ch2

  always @(posedge tmo) begin
    err_total++;
    wrap_up();
  end

  initial begin
    w(60000);
    err_total++;
    wrap_up();
  end

  initial begin
    w(4);
    reset_n <= 1'b1;
    w(1);
    s_reset();
    s_align();
    s_mask();
    s_alarm();
    s_tx1();
    s_ss7();
    s_frame();
    s_timers();
    s_ch2();
    wrap_up();
  end
endmodule : fisr_top_tb

// ### logic/fisr_edge.sv
module fisr_edge #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] lvl,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= lvl;
    end
  end

  assign rise = lvl & ~prev_reg;
  assign fall = ~lvl & prev_reg;
endmodule : fisr_edge

// ### logic/fisr_evt_if.sv
interface fisr_evt_if;
  fisr_pkg::fisr_byte_t set;
  logic rd_clr;
  fisr_pkg::fisr_byte_t mask;
  logic vis;
  fisr_pkg::fisr_byte_t status;
  logic pending;
  modport stat (input set, input rd_clr, input mask, input vis, output status, output pending);
  modport ctl (output set, output rd_clr, output mask, output vis, input status, input pending);
endinterface : fisr_evt_if

// ### logic/fisr_params.svh
`ifndef FISR_PARAMS_SVH
`define FISR_PARAMS_SVH

// Register indices, byte address is four times the index
`define FISR_IDX_HDLC1_TX 8'h69
`define FISR_IDX_ALARMS 8'h6a
`define FISR_IDX_TIMERS_SLIPS 8'h6b
`define FISR_IDX_HDLC2_TX_SLIP 8'h6c
`define FISR_IDX_SUMMARY 8'h6e
`define FISR_IDX_CFG 8'h60
`define FISR_IDX_MASK1 8'h61
`define FISR_IDX_MASK2 8'h62
`define FISR_IDX_MASK3 8'h63
`define FISR_IDX_MASK4 8'h64
`define FISR_IDX_ERRMASK 8'h65

// Config register fields
`define FISR_CFG_SHOWMASK 0
`define FISR_CFG_COS 1
`define FISR_CFG_PRBS 2
`define FISR_CFG_HDLC 3
`define FISR_CFG_SS7 4
`define FISR_CFG_F12 5
`define FISR_CFG_SSIG 6
`define FISR_CFG_SIM 7

`define FISR_CFG_RESET 8'h08
`define FISR_MASK_RESET 8'hff
`define FISR_ERRMASK_RESET 7'h00

// Status bit positions
`define FISR_B1_CASE 7
`define FISR_B1_OVF 6
`define FISR_B1_ALL_SENT 5
`define FISR_B1_UNDERRUN 4
`define FISR_B1_MF_BEGIN 3
`define FISR_B1_SU_OVER 2
`define FISR_B1_LINE_CHG 1
`define FISR_B1_POOL_RDY 0
`define FISR_B3_ERR_SEC 7
`define FISR_B3_ONE_SEC 6
`define FISR_B3_LOOP_CHG 2
`define FISR_B3_SLIP_NEG 1
`define FISR_B3_SLIP_POS 0

// Counts and times
`define FISR_POOL_BYTES 6'd32
`define FISR_F12_FRAMES 5'd24
`define FISR_SEC_TICKS 1544000
`define FISR_LLB_TIME_US 33160
`define FISR_CLK_MHZ 250
`define FISR_LLB_CYCLES (`FISR_LLB_TIME_US * `FISR_CLK_MHZ)

`endif

// ### logic/fisr_pkg.sv
package fisr_pkg;
  typedef logic [7:0] fisr_byte_t;
  typedef logic [6:0] fisr_err_src_t;
endpackage : fisr_pkg

// ### logic/fisr_stat_reg.sv
module fisr_stat_reg (
  input wire logic core_clk,
  input wire logic reset_n,
  fisr_evt_if.stat bus
);
  fisr_pkg::fisr_byte_t stat_reg;
  fisr_pkg::fisr_byte_t keep;

  // Masked events only recorded when visibility is on; set beats clear
  assign keep = bus.set & (~bus.mask | {8{bus.vis}});
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stat_reg <= 8'h00;
    end else begin
      stat_reg <= (bus.rd_clr ? 8'h00 : stat_reg) | keep;
    end
  end

  assign bus.status = stat_reg;
  assign bus.pending = |(stat_reg & ~bus.mask);
endmodule : fisr_stat_reg

// ### logic/fisr_top.sv
`include "fisr_params.svh"

// How it works
// - Reading a status register clears it
// - Masked events not signalled, recorded only with show-mask on
// - Pool full after 32 bytes of open frame
// - Robbed-bit empty per multiframe (every 24 frames in F12), unless serial signaling
// - Overflow flagged when byte lost
// - All sent in HDLC mode only
// - Underrun aborts, holds transmitter until read
// - Flag each transmit multiframe start
// - SS7 error threshold, reissued until valid frame
// - Line open rise or short change
// - Pool ready when 32 bytes writable
// - Alignment regained on fall or sim end
// - Alignment lost on sync loss or sim
// - Multiframe edges in F12 format, sim both
// - Blue/red on rise, any change with option
// - Remote alarm rise, clear, sim end clear
// - Errored second from masked error sources
// - One-second tick from receive line clock
// - Loop code qualified 33.16 ms, enter/leave
// - PRBS sync change when monitor selected
// - Receive slips flagged, sim sets both
// - Transmit slips flagged
// - Summary bit per pending status register
module fisr_top #(
  parameter int ADDR_W = 12,
  parameter int SEC_TICKS = `FISR_SEC_TICKS,
  parameter int LLB_CYCLES = `FISR_LLB_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tx_frame_start,
  input wire logic tx_multiframe_start,
  input wire logic rx1_byte_in,
  input wire logic rx1_fifo_full,
  input wire logic tx1_last_bit_sent,
  input wire logic tx1_fifo_empty,
  input wire logic tx1_fifo_dry,
  input wire logic tx1_message_end_cmd,
  input wire logic su_err_exceed,
  input wire logic su_err_invalid_cause,
  input wire logic rx1_frame_end,
  input wire logic rx1_frame_valid,
  input wire logic tx_line_open,
  input wire logic tx_line_short,
  input wire logic tx1_pool_space,
  input wire logic align_loss_status,
  input wire logic mf_align_loss_status,
  input wire logic blue_alarm_status,
  input wire logic red_alarm_status,
  input wire logic remote_alarm_status,
  input wire logic rx_line_tick,
  input wire fisr_pkg::fisr_err_src_t err_src,
  input wire logic llb_code_raw,
  input wire logic prbs_sync,
  input wire logic rx_slip_neg_evt,
  input wire logic rx_slip_pos_evt,
  input wire logic tx_slip_pos_evt,
  input wire logic tx_slip_neg_evt,
  input wire logic rx2_msg_end,
  input wire logic rx2_frame_start,
  input wire logic rx2_byte_in,
  input wire logic rx2_fifo_full,
  input wire logic rx2_frame_end,
  input wire logic tx2_last_bit_sent,
  input wire logic tx2_fifo_empty,
  input wire logic tx2_fifo_dry,
  input wire logic tx2_message_end_cmd,
  output logic tx1_hold,
  output logic tx2_hold,
  output logic tx1_abort,
  output logic tx2_abort,
  output logic [3:0] global_irq_summary,
  output logic irq_pin
);
  fisr_evt_if isr_if[4] ();
  fisr_pkg::fisr_byte_t cfg_reg;
  fisr_pkg::fisr_byte_t mask_reg[4];
  fisr_pkg::fisr_err_src_t err_mask_reg;
  fisr_pkg::fisr_byte_t rdata_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic acc;
  logic rd;
  logic [7:0] idx;
  logic [3:0] rd_isr;
  logic [4:0] frame_cnt_reg;
  logic [5:0] rx2_cnt_reg;
  logic su_over_rep_reg;
  logic [31:0] tick_cnt_reg;
  logic [31:0] llb_cnt_reg;
  logic llb_state_reg;
  logic err_seen_reg;
  logic tx1_hold_reg;
  logic tx2_hold_reg;
  logic tx1_abort_reg;
  logic tx2_abort_reg;
  logic [10:0] lvl;
  logic [10:0] rise;
  logic [10:0] fall;
  logic sim;
  logic sim_end;
  logic cos_irq;
  logic case_evt;
  logic xdu1_evt;
  logic xdu2_evt;
  logic su_over_evt;
  logic second_evt;
  logic rpf2_evt;
  logic llb_change;

  // Bus slave, zero wait state, always OKAY
  assign acc = hsel & htrans[1] & hready;
  assign rd = acc & ~hwrite;
  assign idx = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, rdata_reg};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else begin
      wr_pend_reg <= acc & hwrite;
      wr_idx_reg <= idx;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_reg <= `FISR_CFG_RESET;
      err_mask_reg <= `FISR_ERRMASK_RESET;
      for (int i = 0; i < 4; i++) begin
        mask_reg[i] <= `FISR_MASK_RESET;
      end
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        `FISR_IDX_CFG: cfg_reg <= hwdata[7:0];
        `FISR_IDX_ERRMASK: err_mask_reg <= hwdata[6:0];
        `FISR_IDX_MASK1: mask_reg[0] <= hwdata[7:0];
        `FISR_IDX_MASK2: mask_reg[1] <= hwdata[7:0];
        `FISR_IDX_MASK3: mask_reg[2] <= hwdata[7:0];
        `FISR_IDX_MASK4: mask_reg[3] <= hwdata[7:0];
        default: cfg_reg <= cfg_reg;
      endcase
    end
  end

  // Read data latched at the address phase edge
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      case (idx)
        `FISR_IDX_HDLC1_TX: rdata_reg <= isr_if[0].status;
        `FISR_IDX_ALARMS: rdata_reg <= isr_if[1].status;
        `FISR_IDX_TIMERS_SLIPS: rdata_reg <= isr_if[2].status;
        `FISR_IDX_HDLC2_TX_SLIP: rdata_reg <= isr_if[3].status;
        `FISR_IDX_SUMMARY: rdata_reg <= {4'h0, global_irq_summary};
        `FISR_IDX_CFG: rdata_reg <= cfg_reg;
        `FISR_IDX_ERRMASK: rdata_reg <= {1'b0, err_mask_reg};
        `FISR_IDX_MASK1: rdata_reg <= mask_reg[0];
        `FISR_IDX_MASK2: rdata_reg <= mask_reg[1];
        `FISR_IDX_MASK3: rdata_reg <= mask_reg[2];
        `FISR_IDX_MASK4: rdata_reg <= mask_reg[3];
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign rd_isr[0] = rd & (idx == `FISR_IDX_HDLC1_TX);
  assign rd_isr[1] = rd & (idx == `FISR_IDX_ALARMS);
  assign rd_isr[2] = rd & (idx == `FISR_IDX_TIMERS_SLIPS);
  assign rd_isr[3] = rd & (idx == `FISR_IDX_HDLC2_TX_SLIP);

  for (genvar g = 0; g < 4; g++) begin : g_isr
    assign isr_if[g].rd_clr = rd_isr[g];
    assign isr_if[g].mask = mask_reg[g];
    assign isr_if[g].vis = cfg_reg[`FISR_CFG_SHOWMASK];
    assign global_irq_summary[g] = isr_if[g].pending;
    fisr_stat_reg u_stat (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .bus(isr_if[g])
    );
  end

  assign irq_pin = |global_irq_summary;

  // Edge detection of status levels
  assign lvl = {tx1_pool_space, prbs_sync, llb_state_reg, sim, remote_alarm_status, red_alarm_status,
                blue_alarm_status, mf_align_loss_status, align_loss_status, tx_line_short, tx_line_open};
  fisr_edge #(.WIDTH(11)) u_edge (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign sim = cfg_reg[`FISR_CFG_SIM];
  assign sim_end = fall[7];
  assign cos_irq = cfg_reg[`FISR_CFG_COS];

  // Transmit frame count for F12 robbed-bit reload
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      frame_cnt_reg <= 5'd0;
    end else if (tx_frame_start) begin
      frame_cnt_reg <= (frame_cnt_reg == `FISR_F12_FRAMES - 5'd1) ? 5'd0 : frame_cnt_reg + 5'd1;
    end
  end
  assign case_evt = ~cfg_reg[`FISR_CFG_SSIG] & (cfg_reg[`FISR_CFG_F12] ?
                    (tx_frame_start & (frame_cnt_reg == `FISR_F12_FRAMES - 5'd1)) : tx_multiframe_start);

  // Underrun aborts and holds until status read
  assign xdu1_evt = tx1_fifo_dry & ~tx1_message_end_cmd;
  assign xdu2_evt = tx2_fifo_dry & ~tx2_message_end_cmd;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx1_hold_reg <= 1'b0;
      tx2_hold_reg <= 1'b0;
      tx1_abort_reg <= 1'b0;
      tx2_abort_reg <= 1'b0;
    end else begin
      tx1_hold_reg <= xdu1_evt | (tx1_hold_reg & ~rd_isr[0]);
      tx2_hold_reg <= xdu2_evt | (tx2_hold_reg & ~rd_isr[3]);
      tx1_abort_reg <= xdu1_evt;
      tx2_abort_reg <= xdu2_evt;
    end
  end
  assign tx1_hold = tx1_hold_reg;
  assign tx2_hold = tx2_hold_reg;
  assign tx1_abort = tx1_abort_reg;
  assign tx2_abort = tx2_abort_reg;

  // SS7 threshold, repeated on invalid frames until a valid one
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      su_over_rep_reg <= 1'b0;
    end else if (rx1_frame_end & rx1_frame_valid) begin
      su_over_rep_reg <= 1'b0;
    end else if (su_err_exceed & su_err_invalid_cause & cfg_reg[`FISR_CFG_SS7]) begin
      su_over_rep_reg <= 1'b1;
    end
  end
  assign su_over_evt = cfg_reg[`FISR_CFG_SS7] &
                       (su_err_exceed | (su_over_rep_reg & rx1_frame_end & ~rx1_frame_valid));

  // Channel 2 receive pool count
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx2_cnt_reg <= 6'd0;
    end else if (rx2_frame_end) begin
      rx2_cnt_reg <= 6'd0;
    end else if (rx2_byte_in & ~rx2_fifo_full) begin
      rx2_cnt_reg <= rpf2_evt ? 6'd0 : rx2_cnt_reg + 6'd1;
    end
  end
  assign rpf2_evt = rx2_byte_in & ~rx2_fifo_full & ~rx2_frame_end &
                    (rx2_cnt_reg == `FISR_POOL_BYTES - 6'd1);

  // One-second timer and errored second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'd0;
    end else if (rx_line_tick) begin
      tick_cnt_reg <= second_evt ? 32'd0 : tick_cnt_reg + 32'd1;
    end
  end
  assign second_evt = rx_line_tick & (tick_cnt_reg == 32'(SEC_TICKS - 1));

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      err_seen_reg <= 1'b0;
    end else begin
      err_seen_reg <= second_evt ? 1'b0 : (err_seen_reg | (|(err_src & err_mask_reg)));
    end
  end

  // Loop code qualification
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      llb_cnt_reg <= 32'd0;
      llb_state_reg <= 1'b0;
    end else if (!llb_code_raw) begin
      llb_cnt_reg <= 32'd0;
      llb_state_reg <= 1'b0;
    end else if (llb_cnt_reg == 32'(LLB_CYCLES - 1)) begin
      llb_state_reg <= 1'b1;
    end else begin
      llb_cnt_reg <= llb_cnt_reg + 32'd1;
    end
  end
  assign llb_change = cfg_reg[`FISR_CFG_PRBS] ? (rise[9] | fall[9]) : (rise[8] | fall[8]);

  assign isr_if[0].set = {case_evt,
                          rx1_byte_in & rx1_fifo_full,
                          cfg_reg[`FISR_CFG_HDLC] & tx1_last_bit_sent & tx1_fifo_empty,
                          xdu1_evt,
                          tx_multiframe_start,
                          su_over_evt,
                          rise[0] | rise[1] | fall[1],
                          rise[10]};
  assign isr_if[1].set = {fall[2] | (sim_end & ~align_loss_status),
                          rise[2] | sim,
                          (cfg_reg[`FISR_CFG_F12] & fall[3]) | sim,
                          (cfg_reg[`FISR_CFG_F12] & rise[3]) | sim,
                          rise[4] | (cos_irq & fall[4]) | sim,
                          rise[5] | (cos_irq & fall[5]) | sim,
                          fall[6] | (sim_end & ~remote_alarm_status),
                          rise[6] | sim};
  assign isr_if[2].set = {second_evt & (err_seen_reg | (|(err_src & err_mask_reg))),
                          second_evt,
                          3'b000,
                          llb_change,
                          rx_slip_neg_evt | sim,
                          rx_slip_pos_evt | sim};
  assign isr_if[3].set = {tx_slip_pos_evt,
                          tx_slip_neg_evt,
                          rx2_msg_end,
                          rx2_frame_start,
                          rx2_byte_in & rx2_fifo_full,
                          cfg_reg[`FISR_CFG_HDLC] & tx2_last_bit_sent & tx2_fifo_empty,
                          xdu2_evt,
                          rpf2_evt};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_read_clears: assert property (rd_isr[1] && isr_if[1].set == 8'h00 |=> isr_if[1].status == 8'h00)
    else $error("status not cleared by read");
  a_masked_quiet: assert property (cfg_reg[`FISR_CFG_SHOWMASK] && mask_reg[1] == 8'hff |-> !global_irq_summary[1])
    else $error("masked status reached summary");
  a_case_suppress: assert property (cfg_reg[`FISR_CFG_SSIG] |-> !isr_if[0].set[`FISR_B1_CASE])
    else $error("robbed-bit empty with serial signaling");
  a_all_sent_flag_hdlc: assert property (!cfg_reg[`FISR_CFG_HDLC] |-> !isr_if[0].set[`FISR_B1_ALL_SENT])
    else $error("all sent outside HDLC mode");
  a_underrun_hold: assert property (xdu1_evt |=> tx1_hold && tx1_abort ##1 !tx1_abort)
    else $error("underrun did not hold transmitter");
  a_hold_release: assert property (tx1_hold && rd_isr[0] && !xdu1_evt |=> !tx1_hold)
    else $error("hold not released by read");
  a_far_fall: assert property ($fell(align_loss_status) && mask_reg[1][7] == 1'b0 |=> isr_if[1].status[7])
    else $error("alignment regained not flagged");
  a_sec_period: assert property (second_evt |=> tick_cnt_reg == 32'd0)
    else $error("second timer not restarted");
  a_irq_follow: assert property (irq_pin == (|{isr_if[0].pending, isr_if[1].pending,
                                 isr_if[2].pending, isr_if[3].pending}))
    else $error("irq pin disagrees with pending");
  a_pool_count: assert property (rpf2_evt |=> rx2_cnt_reg == 6'd0)
    else $error("pool count not restarted");
endmodule : fisr_top
